// ---- logic/local_bus_slave_wait_states.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Retried cycles get exactly one wait state before the retry termination.
// - Burst writes get one wait state before acknowledge.
// - Posted single writes get one wait state before acknowledge.
// - Completing delayed single reads or writes gets two wait states.
// - Completing delayed burst reads gets one wait state on the first beat.
// - Integrated DMA mode cycles are not answered by this timing logic.
// - Register accesses are retried at most twice, then completed.
// - Register read acknowledge comes three clocks after the strobe, two waits.
// - Register write acknowledge comes six clocks after the strobe.
// - Misaligned burst accesses get at least one wait state.
module local_bus_slave_wait_states
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic transfer_start_strobe_n,
  input wire logic addr_valid_strobe_n,
  input wire logic integrated_dma_mode,
  input wire logic [2:0] access_kind,
  input wire logic [wait_pkg::ALIGN_BITS-1:0] start_addr_low,
  input wire logic reg_ready,
  output logic transfer_ack_n,
  output logic sized_port_ack_n,
  output logic bus_error_n,
  output logic retry_n,
  output logic reg_retried
);
  logic rst_s1_r;
  logic rst_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_r <= rst_s1_r;
    end
  end

  wait_if w ();
  wait_counter u_cnt
  (
    .clk(core_clk),
    .rst_n(rst_r),
    .w(w)
  );

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_WAIT,
    ST_END
  } state_t;
  state_t state_r;
  state_t state_nxt;
  wait_pkg::end_kind_t end_r;
  wait_pkg::end_kind_t end_nxt;
  logic [wait_pkg::RETRY_W-1:0] retries_r;
  logic [wait_pkg::RETRY_W-1:0] retries_nxt;

  wait_pkg::access_kind_t kind;
  assign kind = wait_pkg::access_kind_t'(access_kind);
  wire ts_low = !transfer_start_strobe_n;
  wire as_low = !addr_valid_strobe_n;
  wire start = (ts_low || as_low) && !integrated_dma_mode;
  wire taken = (state_r == ST_IDLE) && start;
  wire misaligned = (start_addr_low != '0);
  wire is_posted = (kind == wait_pkg::ACC_POSTED_WRITE);
  wire is_burst_write = (kind == wait_pkg::ACC_BURST_WRITE);
  wire is_delayed = (kind == wait_pkg::ACC_DELAYED_DONE);
  wire is_burst_read = (kind == wait_pkg::ACC_DELAYED_BURST_READ);
  wire is_retry = (kind == wait_pkg::ACC_RETRY);
  wire is_reg_read = (kind == wait_pkg::ACC_REG_READ);
  wire is_reg_write = (kind == wait_pkg::ACC_REG_WRITE);
  wire is_error = (kind == wait_pkg::ACC_BUS_ERROR);
  wire is_burst = is_burst_write || is_burst_read;
  wire is_reg = is_reg_read || is_reg_write;
  wire retry_cap = (retries_r == wait_pkg::RETRY_W'(wait_pkg::REG_RETRY_MAX));
  wire reg_retry = is_reg && !reg_ready && !retry_cap;

  // Register timing counts from the strobe clock, so the waits are the clocks minus the strobe clock alone.
  wire [wait_pkg::CNT_W-1:0] retry_waits = wait_pkg::CNT_W'(wait_pkg::WS_RETRY);
  wire [wait_pkg::CNT_W-1:0] posted_waits = wait_pkg::CNT_W'(wait_pkg::WS_POSTED_WRITE);
  wire [wait_pkg::CNT_W-1:0] burst_write_waits = wait_pkg::CNT_W'(wait_pkg::WS_BURST_WRITE);
  wire [wait_pkg::CNT_W-1:0] delayed_waits = wait_pkg::CNT_W'(wait_pkg::WS_DELAYED_DONE);
  wire [wait_pkg::CNT_W-1:0] burst_read_waits = wait_pkg::CNT_W'(wait_pkg::WS_DELAYED_BURST_READ);
  wire [wait_pkg::CNT_W-1:0] reg_read_waits = wait_pkg::CNT_W'(wait_pkg::REG_READ_CLKS - 1);
  wire [wait_pkg::CNT_W-1:0] reg_write_waits = wait_pkg::CNT_W'(wait_pkg::REG_WRITE_CLKS - 1);
  wire [wait_pkg::CNT_W-1:0] misaligned_waits = wait_pkg::CNT_W'(wait_pkg::WS_MISALIGNED_MIN);
  // Bus error and plain retry terminations reuse the single retry wait.
  wire [wait_pkg::CNT_W-1:0] base_waits =
    is_posted ? posted_waits :
    is_burst_write ? burst_write_waits :
    is_delayed ? delayed_waits :
    is_burst_read ? burst_read_waits :
    is_reg_read ? reg_read_waits :
    is_reg_write ? reg_write_waits :
    retry_waits;
  wire [wait_pkg::CNT_W-1:0] picked_waits = reg_retry ? retry_waits : base_waits;
  wire too_few = is_burst && misaligned && (picked_waits < misaligned_waits);
  wire [wait_pkg::CNT_W-1:0] waits_sel = too_few ? misaligned_waits : picked_waits;
  // The counter loads the wait count less one because its terminal cycle is itself a wait.
  assign w.load = taken;
  assign w.waits = waits_sel - 1'b1;

  always_comb
  begin
    state_nxt = state_r;
    end_nxt = end_r;
    retries_nxt = retries_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = ST_WAIT;
          if (is_retry || reg_retry)
            end_nxt = wait_pkg::END_RETRY;
          else if (is_error)
            end_nxt = wait_pkg::END_ERROR;
          else
            end_nxt = wait_pkg::END_ACK;
          if (reg_retry)
            retries_nxt = retries_r + 1'b1;
          else if (is_reg)
            retries_nxt = '0;
        end
      end
      ST_WAIT:
        if (w.done)
          state_nxt = ST_END;
      ST_END:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      end_r <= wait_pkg::END_ACK;
    end
    else
    begin
      end_r <= end_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      retries_r <= '0;
    end
    else
    begin
      retries_r <= retries_nxt;
    end
  end

  // Outputs are registered so the pins never glitch during a wait.
  wire term_nxt = (state_r == ST_WAIT) && w.done;
  wire ack_nxt = term_nxt && (end_r == wait_pkg::END_ACK);
  wire error_nxt = term_nxt && (end_r == wait_pkg::END_ERROR);
  wire retry_nxt = term_nxt && (end_r == wait_pkg::END_RETRY);
  wire retried_nxt = (retries_r != '0);
  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      transfer_ack_n <= 1'b1;
    end
    else
    begin
      transfer_ack_n <= !ack_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      sized_port_ack_n <= 1'b1;
    end
    else
    begin
      sized_port_ack_n <= !ack_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      bus_error_n <= 1'b1;
    end
    else
    begin
      bus_error_n <= !error_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      retry_n <= 1'b1;
    end
    else
    begin
      retry_n <= !retry_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      reg_retried <= 1'b0;
    end
    else
    begin
      reg_retried <= retried_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- include/wait_pkg.sv ----
`default_nettype none
package wait_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned WS_RETRY = 1;
  localparam int unsigned WS_BURST_WRITE = 1;
  localparam int unsigned WS_POSTED_WRITE = 1;
  localparam int unsigned WS_DELAYED_DONE = 2;
  localparam int unsigned WS_DELAYED_BURST_READ = 1;
  localparam int unsigned WS_MISALIGNED_MIN = 1;
  localparam int unsigned REG_READ_CLKS = 3;
  localparam int unsigned REG_WRITE_CLKS = 6;
  localparam int unsigned REG_RETRY_MAX = 2;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned RETRY_W = 2;
  localparam int unsigned ALIGN_BITS = 4;
  typedef enum logic [2:0]
  {
    ACC_POSTED_WRITE,
    ACC_BURST_WRITE,
    ACC_DELAYED_DONE,
    ACC_DELAYED_BURST_READ,
    ACC_RETRY,
    ACC_REG_READ,
    ACC_REG_WRITE,
    ACC_BUS_ERROR
  } access_kind_t;
  typedef enum logic [1:0]
  {
    END_ACK,
    END_RETRY,
    END_ERROR
  } end_kind_t;
endpackage
`default_nettype wire

// ---- include/wait_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface wait_if;
  logic load;
  logic [wait_pkg::CNT_W-1:0] waits;
  logic done;
  modport ctrl
  (
    output load,
    output waits,
    input done
  );
  modport cnt
  (
    input load,
    input waits,
    output done
  );
endinterface
`default_nettype wire

// ---- logic/wait_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
module wait_counter
(
  input wire logic clk,
  input wire logic rst_n,
  wait_if.cnt w
);
  logic [wait_pkg::CNT_W-1:0] cnt_r;
  logic busy_r;
  wire last = busy_r && (cnt_r == '0);
  assign w.done = last;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end
    else if (w.load)
    begin
      cnt_r <= w.waits;
      busy_r <= 1'b1;
    end
    else if (last)
      busy_r <= 1'b0;
    else if (busy_r)
      cnt_r <= cnt_r - 1'b1;
  end
endmodule
`default_nettype wire

// ---- tb/bus_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bus_master_model
(
  input wire logic clk,
  input wire logic [2:0] end_n,
  output logic start_n
);
  initial start_n = 1'h1;
  task automatic run(output int k, output logic [2:0] e);
    @(negedge clk);
    start_n = 1'h0;
    @(negedge clk);
    start_n = 1'h1;
    // The clock that took the strobe counts as the first one.
    // Waits are counted rather than assumed, since register cycles may stretch.
    k = 1;
    e = end_n;
    while (e == 3'h7 && k < 12)
    begin
      @(negedge clk);
      k++;
      e = end_n;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/lsw_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module lsw_chk
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic transfer_start_strobe_n,
  input wire logic addr_valid_strobe_n,
  input wire logic integrated_dma_mode,
  input wire logic [2:0] access_kind,
  input wire logic reg_ready,
  input wire logic transfer_ack_n,
  input wire logic sized_port_ack_n,
  input wire logic bus_error_n,
  input wire logic retry_n
);
  wire logic s = (!transfer_start_strobe_n || !addr_valid_strobe_n) && !integrated_dma_mode;
  wire logic q = transfer_ack_n && bus_error_n && retry_n;
  wire logic [2:0] k = access_kind;
  wire logic a = transfer_ack_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_post_wait: assert property (s && k == 3'h0 |=> q ##1 !a) else $error("wrong wait count");
  a_burst_wait: assert property (s && k == 3'h1 |=> q ##1 !a) else $error("wrong wait count");
  a_delay_wait: assert property (s && k == 3'h2 |=> q [*2] ##1 !a) else $error("wrong wait count");
  a_dread_wait: assert property (s && k == 3'h3 |=> q ##1 !a) else $error("wrong wait count");
  a_retry_wait: assert property (s && k == 3'h4 |=> q ##1 !retry_n) else $error("wrong wait count");
  a_berr_wait: assert property (s && k == 3'h7 |=> q ##1 !bus_error_n) else $error("wrong wait count");
  a_reg_read: assert property (s && k == 3'h5 && reg_ready |=> q [*2] ##1 !a) else $error("wrong wait count");
  a_reg_write: assert property (s && k == 3'h6 && reg_ready |=> q [*5] ##1 !a) else $error("wrong wait count");
  a_dma_quiet: assert property (integrated_dma_mode [*3] |-> q) else $error("answered");
  a_ack_pair: assert property (sized_port_ack_n == transfer_ack_n) else $error("ack pins differ");
endmodule
bind local_bus_slave_wait_states lsw_chk u_lsw_chk
(
  .core_clk, .rstn, .transfer_start_strobe_n, .addr_valid_strobe_n, .integrated_dma_mode, .access_kind,
  .reg_ready, .transfer_ack_n, .sized_port_ack_n, .bus_error_n, .retry_n
);
`default_nettype wire

// ---- tb/test_local_bus_slave_wait_states.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_local_bus_slave_wait_states;
  logic core_clk = 1'h0, rstn = 1'h0, integrated_dma_mode = 1'h0, reg_ready = 1'h1;
  logic [2:0] access_kind = 3'h0;
  logic [3:0] start_addr_low = 4'h0;
  logic use_as = 1'h0;
  wire logic transfer_ack_n, bus_error_n, retry_n, reg_retried, strobe_n;
  int mismatches = 0, checks = 0;
  local_bus_slave_wait_states u_local_bus_slave_wait_states
  (
    .core_clk, .rstn, .transfer_start_strobe_n(strobe_n || use_as), .addr_valid_strobe_n(strobe_n || !use_as),
    .integrated_dma_mode, .access_kind, .start_addr_low, .reg_ready, .transfer_ack_n, .sized_port_ack_n(),
    .bus_error_n, .retry_n, .reg_retried
  );
  bus_master_model u_bus_master_model
  (
    .clk(core_clk), .end_n({transfer_ack_n, bus_error_n, retry_n}), .start_n(strobe_n)
  );
  initial forever #12.5 core_clk = ~core_clk;
  initial
  begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    final_report;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // The code packs ready, low address and kind, so each access fits one line.
  task automatic acc(input logic [7:0] c, input int n, input logic [2:0] x);
    int k;
    logic [2:0] e;
    @(negedge core_clk);
    {reg_ready, start_addr_low, access_kind} = c;
    u_bus_master_model.run(k, e);
    checks += 2;
    if (k != n || e !== x)
    begin
      mismatches++;
      $display("[ERR] termination expected %0d %h seen %0d %h", n, x, k, e);
    end
  endtask
  task automatic flag(input logic x);
    checks++;
    if (reg_retried !== x)
    begin
      mismatches++;
      $display("[ERR] reg_retried expected %h seen %h", x, reg_retried);
    end
  endtask
  task automatic t_bulk;
    acc(8'h80, 2, 3'h3);
    acc(8'ha1, 2, 3'h3);
    acc(8'h82, 3, 3'h3);
    acc(8'hc3, 2, 3'h3);
    acc(8'h84, 2, 3'h6);
    acc(8'h87, 2, 3'h5);
    $display("bulk test done");
  endtask
  task automatic t_regs;
    use_as = 1'h1;
    acc(8'h85, 3, 3'h3);
    use_as = 1'h0;
    acc(8'h86, 6, 3'h3);
    flag(1'h0);
    acc(8'h05, 2, 3'h6);
    flag(1'h1);
    acc(8'h06, 2, 3'h6);
    acc(8'h05, 3, 3'h3);
    flag(1'h0);
    $display("register test done");
  endtask
  task automatic t_dma;
    integrated_dma_mode = 1'h1;
    acc(8'h80, 12, 3'h7);
    integrated_dma_mode = 1'h0;
    $display("dma test done");
  endtask
  initial
  begin
    repeat (8) @(negedge core_clk);
    rstn = 1'h1;
    repeat (4) @(negedge core_clk);
    t_bulk;
    t_regs;
    t_dma;
    final_report;
  end
endmodule
`default_nettype wire
